/* File: prx_params.svh */
`ifndef PRX_PARAMS_SVH
`define PRX_PARAMS_SVH

// register byte addresses
`define PRX_ADDR_W       12
`define PRX_OFF_DETECT   12'h15c
`define PRX_OFF_INSERT   12'h160
`define PRX_OFF_CFMOD    12'h164
`define PRX_OFF_FILTER   12'h168
`define PRX_OFF_SELECT   12'h1fc

// bank holding the per-port registers
`define PRX_PORT_BANK    3'h1

// reset values and the filter field mask
`define PRX_RST_DETECT   32'h0002_0000
`define PRX_RST_TS_OFF   6'h10
`define PRX_RST_SEC_OFF  6'h05
`define PRX_RST_CF_MASK  16'h000f
`define PRX_FILTER_MASK  32'h0007_ffff

// insertion register fields
`define PRX_B_DREQ       17
`define PRX_B_CKDIS      16
`define PRX_B_SECEN      15
`define PRX_F_SEC_LSB    8
`define PRX_B_TSEN       7
`define PRX_F_TS_LSB     0

// bank / port select register fields
`define PRX_F_BANK_LSB   0
`define PRX_F_PORT_LSB   4

// message type of a delay response
`define PRX_TYPE_DRESP   4'h9

// stream buffer
`define PRX_FIFO_DEPTH   16
`define PRX_FIFO_W       14

`endif

/* File: prx_pkg.sv */
package prx_pkg;

   typedef enum logic {FR_IDLE, FR_BODY} prx_fr_state_t;

   typedef struct packed {
      logic [31:0] detect;
      logic        dreq_en;
      logic        ckdis;
      logic        sec_en;
      logic [5:0]  sec_off;
      logic        ts_en;
      logic [5:0]  ts_off;
      logic [15:0] cf_mask;
      logic [18:0] filter;
   } prx_port_cfg_t;

   typedef struct packed {
      prx_fr_state_t state;
      logic [6:0]    cnt;
      logic [1:0]    port;
      logic          ts_ins;
      logic          sec_ins;
      logic          cf;
      logic          sym_err;
      logic [31:0]   ns;
      logic [3:0]    sec;
   } prx_frame_t;

endpackage

/* File: prx_stream_if.sv */
`timescale 1ns/1ns
interface prx_stream_if #(parameter int W = 8);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* File: prx_fifo.sv */
`timescale 1ns/1ns
module prx_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   input  wire logic ref_clk,
   input  wire logic arst_n,
   prx_stream_if.snk wr,
   prx_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0]             wp;
      logic [AW:0]             rp;
   } prx_fifo_state_t;

   prx_fifo_state_t st_reg;
   prx_fifo_state_t st_next;
   logic            full;
   logic            empty;

   // extra pointer bit tells full from empty
   assign full  = (st_reg.wp[AW] != st_reg.rp[AW]) && (st_reg.wp[AW-1:0] == st_reg.rp[AW-1:0]);
   assign empty = st_reg.wp == st_reg.rp;
   assign wr.ready = ~full;
   assign rd.valid = ~empty;
   assign rd.data  = st_reg.mem[st_reg.rp[AW-1:0]];

   // push and pop may happen in the same cycle
   always_comb begin
      st_next = st_reg;
      if (wr.valid && !full) begin
         st_next.mem[st_reg.wp[AW-1:0]] = wr.data;
         st_next.wp = st_reg.wp + 1'b1;
      end
      if (rd.ready && !empty) begin
         st_next.rp = st_reg.rp + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule // prx_fifo

/* File: prx_rx_insert.sv */
// How it works
// (RULE1) insert enable on: qualifying ptp frames get ingress time; off: nothing inserted
// (RULE2) ingress time lands at the six-bit header offset, reset 16
// (RULE3) seconds low nibble inserted only when both insert and seconds enables set
// (RULE4) seconds nibble lands at its own six-bit offset, reset 5
// (RULE5) delay response frames get egress time of the last delay request
// (RULE6) that needs insert enable and delay response detection enabled too
// (RULE7) disable clear: modified frame with bad udp checksum gets symbol error
// (RULE8) disable set: checksum ignored, no symbol error forced
// (RULE9) correction field modified only when the mask bit of its type is set
// (RULE10) mask bit n selects message type n, sync is bit zero
// (RULE11) software keeps offsets and disable bit still while timestamping runs
// (RULE12) per-port registers decode only when bank select equals one
// (RULE13) port select picks which port's registers an access reaches
// (RULE14) reserved bits read zero; writable fields read back last write
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ns
`include "prx_params.svh"
module prx_rx_insert
   import prx_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  arst_n,
   input  wire logic [`PRX_ADDR_W-1:0] avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output      logic [31:0]           avs_readdata,
   output      logic                  avs_waitrequest,
   input  wire logic                  rx_valid,
   output      logic                  rx_ready,
   input  wire logic [7:0]            rx_data,
   input  wire logic                  rx_first,
   input  wire logic                  rx_last,
   input  wire logic [1:0]            rx_port,
   input  wire logic                  rx_is_ptp,
   input  wire logic [3:0]            rx_msg_type,
   input  wire logic                  rx_udp_bad,
   input  wire logic [29:0]           rx_ingress_ns,
   input  wire logic [3:0]            rx_ingress_sec,
   input  wire logic [3:0][29:0]      dreq_egress_ns,
   output      logic                  tx_valid,
   input  wire logic                  tx_ready,
   output      logic [7:0]            tx_data,
   output      logic                  tx_first,
   output      logic                  tx_last,
   output      logic [1:0]            tx_port,
   output      logic                  tx_sym_err,
   output      logic                  tx_cf_modify
);

   typedef struct packed {
      prx_port_cfg_t [3:0] cfg;
      logic [2:0]          bank_sel;
      logic [1:0]          port_sel;
      logic                ack;
      logic [31:0]         rdata;
      prx_frame_t          fr;
   } prx_state_t;

   prx_state_t st_reg;
   prx_state_t st_next;

   prx_stream_if #(.W(`PRX_FIFO_W)) push_if ();
   prx_stream_if #(.W(`PRX_FIFO_W)) pop_if ();

   prx_fifo #(
      .W     (`PRX_FIFO_W),
      .DEPTH (`PRX_FIFO_DEPTH)
   ) u_fifo (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .wr      (push_if.snk),
      .rd      (pop_if.src)
   );

   // byte-lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] old_w,
                                         input logic [31:0] new_w,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old_w;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = new_w[8*i +: 8];
         end
      end
      return r;
   endfunction

   // insertion register image, reserved bits zero
   function automatic logic [31:0] ins_word(input prx_port_cfg_t c);
      logic [31:0] r;
      r = '0;
      r[`PRX_B_DREQ]              = c.dreq_en;
      r[`PRX_B_CKDIS]             = c.ckdis;
      r[`PRX_B_SECEN]             = c.sec_en;
      r[`PRX_F_SEC_LSB +: 6]      = c.sec_off;
      r[`PRX_B_TSEN]              = c.ts_en;
      r[`PRX_F_TS_LSB +: 6]       = c.ts_off;
      return r;
   endfunction

   logic          req;
   logic          port_hit;
   logic [31:0]   rd_word;
   logic [31:0]   wm;
   prx_port_cfg_t sel_cfg;
   prx_port_cfg_t in_cfg;
   prx_port_cfg_t fr_cfg;
   prx_frame_t    fresh;
   prx_frame_t    cur;
   logic          fresh_dreq;
   logic          fresh_qual;
   logic [6:0]    idx;
   logic [6:0]    d_ns;
   logic [7:0]    out_byte;
   logic          beat;
   logic          modified;

   assign req      = avs_read | avs_write;
   assign port_hit = st_reg.bank_sel == `PRX_PORT_BANK; // (RULE12)
   assign sel_cfg  = st_reg.cfg[st_reg.port_sel]; // (RULE13)
   assign in_cfg   = st_reg.cfg[rx_port];

   // one wait state, so read data and write commit share the release edge
   assign avs_waitrequest = req & ~st_reg.ack;
   assign avs_readdata    = st_reg.rdata;

   // stream handshake goes straight through to the buffer
   assign rx_ready       = push_if.ready;
   assign push_if.valid  = rx_valid;
   assign beat           = rx_valid & push_if.ready;
   assign tx_valid       = pop_if.valid;
   assign pop_if.ready   = tx_ready;
   assign {tx_port, tx_cf_modify, tx_sym_err, tx_first, tx_last, tx_data} = pop_if.data;

   // register read mux, unmapped and other banks read zero
   always_comb begin
      rd_word = '0;
      if (avs_address == `PRX_OFF_SELECT) begin
         rd_word[`PRX_F_BANK_LSB +: 3] = st_reg.bank_sel;
         rd_word[`PRX_F_PORT_LSB +: 2] = st_reg.port_sel;
      end else if (port_hit) begin // (RULE12)
         unique case (avs_address)
            `PRX_OFF_DETECT: rd_word = sel_cfg.detect;
            `PRX_OFF_INSERT: rd_word = ins_word(sel_cfg); // (RULE14)
            `PRX_OFF_CFMOD:  rd_word = {16'h0000, sel_cfg.cf_mask}; // (RULE14)
            `PRX_OFF_FILTER: rd_word = {13'h0000, sel_cfg.filter}; // (RULE14)
            default:         rd_word = '0;
         endcase
      end
   end

   // per-frame decisions taken from the first beat's sideband
   always_comb begin
      fresh_qual = rx_is_ptp & in_cfg.detect[rx_msg_type];
      fresh_dreq = in_cfg.dreq_en & in_cfg.ts_en & in_cfg.detect[`PRX_TYPE_DRESP]
                   & rx_is_ptp & (rx_msg_type == `PRX_TYPE_DRESP); // (RULE5) (RULE6)
      fresh         = '0;
      fresh.state   = FR_BODY;
      fresh.port    = rx_port;
      fresh.ts_ins  = in_cfg.ts_en & fresh_qual; // (RULE1)
      fresh.sec_ins = in_cfg.ts_en & in_cfg.sec_en & fresh_qual; // (RULE3)
      fresh.cf      = rx_is_ptp & in_cfg.cf_mask[rx_msg_type]; // (RULE9) (RULE10)
      // delay response carries the stored request egress time instead
      fresh.ns      = fresh_dreq ? {2'b00, dreq_egress_ns[rx_port]}
                                 : {2'b00, rx_ingress_ns}; // (RULE5)
      fresh.sec     = rx_ingress_sec;
      // checksum only matters if the frame is really modified
      fresh.sym_err = rx_udp_bad & ~in_cfg.ckdis
                      & (fresh.ts_ins | fresh.cf); // (RULE7) (RULE8)
   end

   // byte editing; a stray beat outside a frame passes untouched
   always_comb begin
      if (rx_first) begin
         cur = fresh;
         idx = '0;
      end else if (st_reg.fr.state == FR_BODY) begin
         cur = st_reg.fr;
         idx = st_reg.fr.cnt;
      end else begin
         cur = '0;
         idx = st_reg.fr.cnt;
      end
      fr_cfg   = st_reg.cfg[cur.port];
      d_ns     = idx - {1'b0, fr_cfg.ts_off};
      out_byte = rx_data;
      if (cur.ts_ins && idx >= {1'b0, fr_cfg.ts_off} && d_ns < 7'h04) begin // (RULE2)
         out_byte = cur.ns[8*(3 - d_ns[1:0]) +: 8]; // big-endian, msb first
      end
      // seconds win where the two fields overlap
      if (cur.sec_ins && idx == {1'b0, fr_cfg.sec_off}) begin // (RULE4)
         out_byte = {out_byte[7:4], cur.sec}; // (RULE3)
      end
      modified = cur.ts_ins | cur.cf;
   end

   // buffer word: port, cf flag, symbol error on last byte, framing, data
   assign push_if.data = {cur.port, cur.cf & modified, cur.sym_err & rx_last,
                          rx_first, rx_last, out_byte}; // (RULE7)

   // next-state: bus slave and frame tracker
   always_comb begin
      st_next     = st_reg;
      st_next.ack = req & ~st_reg.ack;
      if (req && !st_reg.ack) begin
         st_next.rdata = rd_word;
      end
      wm = '0;
      if (avs_write && st_reg.ack) begin
         if (avs_address == `PRX_OFF_SELECT) begin
            wm = merge({26'h0, st_reg.port_sel, 1'b0, st_reg.bank_sel},
                       avs_writedata, avs_byteenable);
            st_next.bank_sel = wm[`PRX_F_BANK_LSB +: 3];
            st_next.port_sel = wm[`PRX_F_PORT_LSB +: 2]; // (RULE13)
         end else if (port_hit) begin // (RULE12)
            unique case (avs_address)
               `PRX_OFF_DETECT: begin
                  st_next.cfg[st_reg.port_sel].detect =
                     merge(sel_cfg.detect, avs_writedata, avs_byteenable);
               end
               `PRX_OFF_INSERT: begin
                  wm = merge(ins_word(sel_cfg), avs_writedata, avs_byteenable);
                  st_next.cfg[st_reg.port_sel].dreq_en = wm[`PRX_B_DREQ];
                  st_next.cfg[st_reg.port_sel].ckdis   = wm[`PRX_B_CKDIS];
                  st_next.cfg[st_reg.port_sel].sec_en  = wm[`PRX_B_SECEN];
                  st_next.cfg[st_reg.port_sel].sec_off = wm[`PRX_F_SEC_LSB +: 6];
                  st_next.cfg[st_reg.port_sel].ts_en   = wm[`PRX_B_TSEN];
                  st_next.cfg[st_reg.port_sel].ts_off  = wm[`PRX_F_TS_LSB +: 6];
               end
               `PRX_OFF_CFMOD: begin
                  wm = merge({16'h0000, sel_cfg.cf_mask}, avs_writedata, avs_byteenable);
                  st_next.cfg[st_reg.port_sel].cf_mask = wm[15:0]; // (RULE14)
               end
               `PRX_OFF_FILTER: begin
                  wm = merge({13'h0000, sel_cfg.filter}, avs_writedata, avs_byteenable);
                  st_next.cfg[st_reg.port_sel].filter = wm[18:0]; // (RULE14)
               end
               default: begin
               end
            endcase
         end
      end
      // byte counter saturates well past the largest offset
      if (beat) begin
         if (rx_last) begin
            st_next.fr       = '0;
            st_next.fr.state = FR_IDLE;
         end else begin
            st_next.fr     = cur;
            st_next.fr.state = rx_first ? FR_BODY : st_reg.fr.state;
            st_next.fr.cnt = (idx == 7'h7f) ? idx : idx + 7'h01;
         end
      end
   end

   // reset gives documented defaults on every port
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg          <= '0;
         st_reg.fr.state <= FR_IDLE;
         for (int p = 0; p < 4; p++) begin
            st_reg.cfg[p].detect  <= `PRX_RST_DETECT;
            st_reg.cfg[p].ts_off  <= `PRX_RST_TS_OFF; // (RULE2)
            st_reg.cfg[p].sec_off <= `PRX_RST_SEC_OFF; // (RULE4)
            st_reg.cfg[p].cf_mask <= `PRX_RST_CF_MASK; // (RULE9)
         end
      end else begin
         st_reg <= st_next;
      end
   end

endmodule // prx_rx_insert

/* File: prx_chk.sv */
`timescale 1ns/1ns
module prx_chk
   import prx_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        arst_n,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        rx_valid,
   input wire logic        rx_ready,
   input wire logic        tx_valid,
   input wire logic        tx_ready,
   input wire logic [7:0]  tx_data,
   input wire logic        tx_first,
   input wire logic        tx_last,
   input wire logic [1:0]  tx_port,
   input wire logic        tx_sym_err,
   input wire logic        tx_cf_modify
);
   logic [4:0] occ_reg;
   logic [4:0] occ_next;

   // bytes in the buffer, counted from both handshakes only
   always_comb occ_next = occ_reg + 5'(rx_valid && rx_ready) - 5'(tx_valid && tx_ready);
   always_ff @(posedge ref_clk or negedge arst_n)
      if (!arst_n) occ_reg <= 5'h00;
      else occ_reg <= occ_next;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   // bus steps and a mid-frame pop
   sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence s_ans; (avs_read || avs_write) && !avs_waitrequest; endsequence
   sequence s_mid; tx_valid && tx_ready && !tx_last; endsequence

   chk_one_wait: assert property (s_req |=> !avs_waitrequest)
      else $error("bus answer not after one wait");
   chk_ans_once: assert property (s_ans |=> avs_waitrequest || !(avs_read || avs_write))
      else $error("bus answered twice");
   chk_rd_stand: assert property (!(avs_read || avs_write) |=> $stable(avs_readdata))
      else $error("read data moved while idle");
   chk_buf_full: assert property (rx_ready == (occ_reg < 5'h10))
      else $error("rx ready does not match buffer fill");
   chk_buf_empty: assert property (tx_valid == (occ_reg != 5'h00))
      else $error("tx valid does not match buffer fill");
   chk_tx_hold: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable({tx_data, tx_first, tx_last, tx_port}))
      else $error("stalled byte changed");
   chk_err_last: assert property (tx_valid && tx_sym_err |-> tx_last)
      else $error("symbol error off the last byte");
   chk_cf_frame: assert property (s_mid ##1 tx_valid |->
      tx_cf_modify == $past(tx_cf_modify) && !tx_first)
      else $error("correction flag changed inside frame");
endmodule // prx_chk

bind prx_rx_insert prx_chk i_prx_chk (.ref_clk(ref_clk), .arst_n(arst_n),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_ready(rx_ready),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_first(tx_first),
   .tx_last(tx_last), .tx_port(tx_port), .tx_sym_err(tx_sym_err),
   .tx_cf_modify(tx_cf_modify));

/* File: prx_src.sv */
`timescale 1ns/1ns
module prx_src
   import prx_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rx_ready,
   output      logic       rx_valid,
   output      logic [7:0] rx_data,
   output      logic       rx_first,
   output      logic       rx_last
);
   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      rx_first = 1'b0;
      rx_last  = 1'b0;
   end

   // byte value follows position so the far end can predict it
   task automatic send(input int len);
      for (int i = 0; i < len; i++) begin
         rx_valid <= 1'b1;
         rx_data  <= 8'(i) ^ 8'h5a;
         rx_first <= (i == 0);
         rx_last  <= (i == len - 1);
         do @(posedge ref_clk); while (rx_ready !== 1'b1); // byte taken at this edge
      end
      rx_valid <= 1'b0;
      rx_data  <= ~rx_data; // released line must not show a stale byte
   endtask
endmodule // prx_src

/* File: tb_top.sv */
`timescale 1ns/1ns
module tb_top
   import prx_pkg::*;
;
   typedef struct packed {
      logic [31:0] det;
      logic [31:0] ins;
      logic [15:0] msk;
      logic [3:0]  typ;
      logic        bad;
   } prx_row_t;
   localparam int          FLEN = 40;
   localparam logic [29:0] NS   = 30'h1234_5678;
   localparam logic [29:0] EGR  = 30'h0765_4321;
   localparam logic [3:0]  SEC  = 4'h9;
   localparam prx_row_t    ROWS [12] = '{
      '{32'h0000ffff, 32'h00000510, 16'h000f, 4'h0, 1'b0},
      '{32'h0000ffff, 32'h00000590, 16'h0000, 4'h0, 1'b0},
      '{32'h0000ffff, 32'h00008a83, 16'h000f, 4'h1, 1'b0},
      '{32'h0000ffff, 32'h00008a03, 16'h000f, 4'h2, 1'b0},
      '{32'h0000ffff, 32'h00020590, 16'h0000, 4'h9, 1'b0},
      '{32'h0000fdff, 32'h00020590, 16'h0000, 4'h9, 1'b0},
      '{32'h0000ffff, 32'h00020510, 16'h0000, 4'h9, 1'b0},
      '{32'h0000ffff, 32'h00000590, 16'h0000, 4'h3, 1'b1},
      '{32'h0000ffff, 32'h00010590, 16'h0000, 4'h3, 1'b1},
      '{32'h0000ffff, 32'h00000510, 16'h0020, 4'h5, 1'b1},
      '{32'h0000ffff, 32'h00000510, 16'h000f, 4'h5, 1'b1},
      '{32'h0000ffff, 32'h00009290, 16'h0000, 4'h4, 1'b0}};

   logic        ref_clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [11:0] avs_address = 12'h000;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic [3:0]  avs_byteenable = 4'hf, rx_msg_type = 4'h0;
   logic        avs_waitrequest, rx_valid, rx_ready, rx_first, rx_last;
   logic [7:0]  rx_data, tx_data;
   logic        rx_is_ptp = 1'b1, rx_udp_bad = 1'b0, tx_ready = 1'b1;
   logic        tx_valid, tx_first, tx_last, tx_sym_err, tx_cf_modify;
   logic [1:0]  rx_port = 2'h1, tx_port, mode = 2'h1;
   logic [13:0] got [$];
   int          error_cnt = 0, samples_checked = 0, cyc = 0;

   prx_src i_prx_src (.ref_clk(ref_clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_first(rx_first), .rx_last(rx_last));
   prx_rx_insert i_prx_rx_insert (.ref_clk(ref_clk), .arst_n(arst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_first(rx_first),
      .rx_last(rx_last), .rx_port(rx_port), .rx_is_ptp(rx_is_ptp),
      .rx_msg_type(rx_msg_type), .rx_udp_bad(rx_udp_bad), .rx_ingress_ns(NS),
      .rx_ingress_sec(SEC), .dreq_egress_ns({30'h3, 30'h2, EGR, 30'h0}),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_first(tx_first),
      .tx_last(tx_last), .tx_port(tx_port), .tx_sym_err(tx_sym_err),
      .tx_cf_modify(tx_cf_modify));

   // clock, far-end stall pattern, output capture and hang guard
   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) tx_ready <= (mode == 2'h2) ? 1'b0 : (mode == 2'h1) ? ~tx_ready : 1'b1;
   always @(posedge ref_clk) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         got.push_back({tx_data, tx_first, tx_last, tx_port, tx_sym_err, tx_cf_modify});
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("mismatches %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string w);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %0t %s got %h exp %h", $time, w, g, e);
      end
   endtask

   // one Avalon transfer; held until waitrequest is seen low
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= !w;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata; // taken at the edge that sees waitrequest low
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge ref_clk); // idle edge keeps back-to-back calls from colliding
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e, "register");
   endtask

   task automatic pops(input int n);
      for (int k = 0; k < 3000 && got.size() < n; k++) @(posedge ref_clk);
      chk(32'(got.size()), 32'(n), "byte count");
   endtask

   // expected byte: ns big-endian at ts offset, seconds nibble wins at its offset
   function automatic logic [7:0] ebyte(input prx_row_t r, input int i);
      logic        ts;
      logic [31:0] ns;
      logic [7:0]  b;
      ts = r.ins[7] && r.det[r.typ];
      ns = {2'b00, (r.ins[17] && r.typ == 4'h9 && r.det[9]) ? EGR : NS};
      b  = 8'(i) ^ 8'h5a;
      if (ts && i >= r.ins[5:0] && i < r.ins[5:0] + 4) b = ns[8 * (3 - (i - r.ins[5:0])) +: 8];
      if (ts && r.ins[15] && i == r.ins[13:8]) b[3:0] = SEC;
      return b;
   endfunction

   initial begin
      logic cf;
      logic se;
      logic [31:0] eb;
      logic [31:0] ef;
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      wr(12'h1fc, 32'h0000_0011);
      // frame rows; config changes only between frames
      foreach (ROWS[n]) begin
         wr(12'h15c, ROWS[n].det);
         wr(12'h160, ROWS[n].ins);
         wr(12'h164, {16'h0, ROWS[n].msk});
         rx_msg_type <= ROWS[n].typ;
         rx_udp_bad  <= ROWS[n].bad;
         got.delete();
         i_prx_src.send(FLEN);
         pops(FLEN);
         cf = ROWS[n].msk[ROWS[n].typ];
         // modified by insertion or correction, bad checksum, check not disabled
         se = (cf || (ROWS[n].ins[7] && ROWS[n].det[ROWS[n].typ]))
              && ROWS[n].bad && !ROWS[n].ins[16];
         for (int i = 0; i < FLEN; i++) begin
            eb = {24'h0, ebyte(ROWS[n], i)};
            ef = {26'h0, i == 0, i == FLEN - 1, 2'h1, se && i == FLEN - 1, cf};
            chk({24'h0, got[i][13:6]}, eb, "frame data");
            chk({26'h0, got[i][5:0]}, ef, "frame flags");
         end
      end
      // port 0 untouched: reset values, then field masks and lanes
      wr(12'h1fc, 32'h0000_0001);
      rd(12'h160, 32'h0000_0510);
      rd(12'h164, 32'h0000_000f);
      rd(12'h168, 32'h0000_0000);
      wr(12'h160, 32'hffff_ffff);
      rd(12'h160, 32'h0003_bfbf);
      wr(12'h164, 32'hffff_ffff);
      rd(12'h164, 32'h0000_ffff);
      wr(12'h168, 32'hffff_ffff);
      rd(12'h168, 32'h0007_ffff);
      avs_byteenable <= 4'h2;
      wr(12'h160, 32'h0000_0000);
      avs_byteenable <= 4'hf;
      rd(12'h160, 32'h0003_00bf);
      rd(12'h100, 32'h0000_0000);
      // bank 0 must not reach the port registers
      wr(12'h1fc, 32'h0000_0000);
      wr(12'h160, 32'h0000_0000);
      rd(12'h160, 32'h0000_0000);
      wr(12'h1fc, 32'h0000_0001);
      rd(12'h160, 32'h0003_00bf);
      wr(12'h1fc, 32'h0000_0021);
      rd(12'h160, 32'h0000_0510);
      // far end stalls until the buffer refuses, then drains
      mode <= 2'h2;
      rx_is_ptp <= 1'b0;
      got.delete();
      @(posedge ref_clk);
      fork
         i_prx_src.send(20);
         begin
            repeat (40) @(posedge ref_clk);
            chk({31'h0, rx_ready}, 32'h0, "buffer full");
            chk(32'(got.size()), 32'h0, "stalled");
            mode <= 2'h0;
         end
      join
      pops(20);
      chk({22'h0, got[19][13:4]}, {22'h0, 8'h49, 2'b01}, "drained");
      // reset in mid-run restores the defaults
      arst_n <= 1'b0;
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      wr(12'h1fc, 32'h0000_0011);
      rd(12'h160, 32'h0000_0510);
      rd(12'h15c, 32'h0002_0000);
      tally_and_finish();
   end
endmodule // tb_top
